// *** adc_seq_pkg.sv ***
`default_nettype none
package adc_seq_pkg;

	localparam int unsigned CLK_HZ = 25_000_000;

	// Internal oscillator frequency of each product variant
	localparam int unsigned OSC_HZ_SLOW = 102_400;
	localparam int unsigned OSC_HZ_MID  = 112_640;
	localparam int unsigned OSC_HZ_FAST = 122_880;

	// Timing in internal oscillator periods
	localparam int unsigned CONV_OSC_PERIODS        = 8192;
	localparam int unsigned SETTLE_OSC_PERIODS      = 32;
	localparam int unsigned FIRST_EXTRA_OSC_PERIODS = 144;

	// Output word layout
	localparam int unsigned CODE_BITS          = 22;
	localparam int unsigned OVERFLOW_HIGH_BIT  = 22;
	localparam int unsigned OVERFLOW_LOW_BIT   = 23;
	localparam int unsigned WORD_BITS          = 24;

	// Counter widths
	localparam int unsigned SETTLE_W = 6;
	localparam int unsigned CONV_W   = 14;
	localparam int unsigned BIT_W    = 5;
	localparam int unsigned DIV_W    = 16;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_SHUTDOWN,
		ST_SETTLE,
		ST_CONVERT,
		ST_SLEEP
	} seq_state_t;

	// System clock cycles per oscillator period, rounded to nearest
	function automatic int unsigned osc_div(input int unsigned hz);
		return (CLK_HZ + hz / 2) / hz;
	endfunction

endpackage
`default_nettype wire

// *** pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int unsigned WIDTH = 3
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t q;
	sync_state_t d;

	// First stage is read only by the second stage
	always_comb
	begin
		d.meta   = i_async;
		d.stable = q.meta;
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			q <= '0;
		else
			q <= d;
	end

	assign o_sync = q.stable;

endmodule
`default_nettype wire

// *** osc_period_gen.sv ***
`timescale 1ns/100ps
`default_nettype none
module osc_period_gen #(
	parameter int unsigned OSC_HZ = adc_seq_pkg::OSC_HZ_SLOW
) (
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	input  wire logic i_run,
	output logic      o_tick
);

	localparam int unsigned DIV_W = adc_seq_pkg::DIV_W;
	localparam int unsigned DIV   = adc_seq_pkg::osc_div(OSC_HZ);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

	typedef struct packed {
		logic [adc_seq_pkg::DIV_W-1:0] cnt;
		logic                          tick;
	} osc_state_t;

	osc_state_t q;
	osc_state_t d;

	always_comb
	begin
		d      = q;
		d.tick = 1'b0;
		if (!i_run)
			d.cnt = '0;
		else if (q.cnt == DIV_LAST)
		begin
			// One pulse per oscillator period, fixed frequency per variant
			d.cnt  = '0;
			d.tick = 1'b1;
		end
		else
			d.cnt = q.cnt + 1'b1;
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			q <= '0;
		else
			q <= d;
	end

	// Gated so a tick in flight never leaks into shutdown
	assign o_tick = q.tick & i_run;

endmodule
`default_nettype wire

// *** adc_power_state_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_power_state_sequencer #(
	parameter int unsigned OSC_HZ       = adc_seq_pkg::OSC_HZ_SLOW,
	parameter int unsigned CONV_PERIODS = adc_seq_pkg::CONV_OSC_PERIODS
) (
	input  wire logic                               i_clk,
	input  wire logic                               i_reset_n,
	input  wire logic                               i_cs_n,
	input  wire logic                               i_sck,
	input  wire logic                               i_supply_ok,
	input  wire logic [adc_seq_pkg::CODE_BITS-1:0]  i_code,
	input  wire logic                               i_over_high,
	input  wire logic                               i_over_low,
	output logic                                    o_data_out_ready_pin,
	output logic                                    o_data_out_ready_oe,
	output logic                                    o_osc_run,
	output logic                                    o_analog_en,
	output logic                                    o_conv_active,
	output logic                                    o_conv_done
);

	localparam int unsigned SETTLE_W = adc_seq_pkg::SETTLE_W;
	localparam int unsigned CONV_W   = adc_seq_pkg::CONV_W;
	localparam int unsigned BIT_W    = adc_seq_pkg::BIT_W;
	localparam int unsigned WORD_W   = adc_seq_pkg::WORD_BITS;

	localparam logic [SETTLE_W-1:0] SETTLE_LAST =
		SETTLE_W'(adc_seq_pkg::SETTLE_OSC_PERIODS - 1);
	localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_PERIODS - 1);
	localparam logic [CONV_W-1:0] FIRST_LAST =
		CONV_W'(CONV_PERIODS + adc_seq_pkg::FIRST_EXTRA_OSC_PERIODS - 1);
	localparam logic [BIT_W-1:0] BIT_ALL = BIT_W'(WORD_W);

	typedef struct packed {
		adc_seq_pkg::seq_state_t st;
		logic                    first;
		logic [SETTLE_W-1:0]     settle_cnt;
		logic [CONV_W-1:0]       conv_cnt;
		logic                    sck_prev;
		logic [BIT_W-1:0]        bit_cnt;
		logic [WORD_W-1:0]       word;
		logic                    pin_out;
		logic                    pin_oe;
		logic                    osc_run;
		logic                    analog_en;
		logic                    conv_active;
		logic                    conv_done;
	} seq_regs_t;

	seq_regs_t q;
	seq_regs_t d;

	logic [2:0]        pins_s;
	logic              cs_n_s;
	logic              sck_s;
	logic              supply_ok_s;
	logic              tick;
	logic              sck_fall;
	logic [CONV_W-1:0] conv_last;
	logic [BIT_W-1:0]  bit_idx;

	pin_sync #(
		.WIDTH (3)
	) u_pin_sync (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_async   ({i_supply_ok, i_sck, i_cs_n}),
		.o_sync    (pins_s)
	);

	assign cs_n_s      = pins_s[0];
	assign sck_s       = pins_s[1];
	assign supply_ok_s = pins_s[2];

	// Oscillator period source, free of any serial edge
	osc_period_gen #(
		.OSC_HZ (OSC_HZ)
	) u_osc (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_run     (q.osc_run),
		.o_tick    (tick)
	);

	assign sck_fall  = q.sck_prev & ~sck_s;
	assign conv_last = q.first ? FIRST_LAST : CONV_LAST;

	always_comb
	begin
		d           = q;
		d.conv_done = 1'b0;
		d.sck_prev  = sck_s;
		bit_idx     = '0;
		case (q.st)
			adc_seq_pkg::ST_RESET:
			begin
				if (supply_ok_s)
				begin
					d.st    = adc_seq_pkg::ST_SETTLE;
					d.first = 1'b0;
				end
			end
			adc_seq_pkg::ST_SHUTDOWN:
			begin
				if (!cs_n_s)
				begin
					d.st    = adc_seq_pkg::ST_SETTLE;
					d.first = 1'b1;
				end
			end
			adc_seq_pkg::ST_SETTLE:
			begin
				if (cs_n_s)
					d.st = adc_seq_pkg::ST_SHUTDOWN;
				else if (tick)
				begin
					if (q.settle_cnt == SETTLE_LAST)
					begin
						d.settle_cnt = '0;
						d.st         = adc_seq_pkg::ST_CONVERT;
					end
					else
						d.settle_cnt = q.settle_cnt + 1'b1;
				end
			end
			adc_seq_pkg::ST_CONVERT:
			begin
				// Raising chip select aborts the conversion
				if (cs_n_s)
					d.st = adc_seq_pkg::ST_SHUTDOWN;
				else if (tick)
				begin
					if (q.conv_cnt == conv_last)
					begin
						d.conv_cnt  = '0;
						d.conv_done = 1'b1;
						d.bit_cnt   = '0;
						d.word      = {i_over_low, i_over_high, i_code};
						d.st        = adc_seq_pkg::ST_SLEEP;
					end
					else
						d.conv_cnt = q.conv_cnt + 1'b1;
				end
			end
			adc_seq_pkg::ST_SLEEP:
			begin
				if (cs_n_s)
					d.st = adc_seq_pkg::ST_SHUTDOWN;
				else if (sck_fall && q.bit_cnt != BIT_ALL)
					d.bit_cnt = q.bit_cnt + 1'b1;
			end
			default:
				d.st = adc_seq_pkg::ST_RESET;
		endcase

		// Monitor is off in shutdown, so a low supply is only seen elsewhere
		if (!supply_ok_s && q.st != adc_seq_pkg::ST_SHUTDOWN)
			d.st = adc_seq_pkg::ST_RESET;

		if (d.st == adc_seq_pkg::ST_RESET || d.st == adc_seq_pkg::ST_SHUTDOWN)
		begin
			d.settle_cnt = '0;
			d.conv_cnt   = '0;
			d.bit_cnt    = '0;
		end

		d.osc_run     = d.st != adc_seq_pkg::ST_RESET && d.st != adc_seq_pkg::ST_SHUTDOWN;
		d.analog_en   = d.st != adc_seq_pkg::ST_SHUTDOWN;
		d.conv_active = d.st == adc_seq_pkg::ST_CONVERT;

		// Pin is released whenever chip select is high
		d.pin_oe = !cs_n_s;
		if (d.st == adc_seq_pkg::ST_SLEEP)
		begin
			bit_idx   = BIT_ALL - d.bit_cnt;
			d.pin_out = (d.bit_cnt == '0) ? 1'b0 : d.word[bit_idx];
		end
		else
			d.pin_out = 1'b1;
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			q <= '0;
		else
			q <= d;
	end

	assign o_data_out_ready_pin = q.pin_out;
	assign o_data_out_ready_oe  = q.pin_oe;
	assign o_osc_run            = q.osc_run;
	assign o_analog_en          = q.analog_en;
	assign o_conv_active        = q.conv_active;
	assign o_conv_done          = q.conv_done;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	sequence s_settle_done;
		q.st == adc_seq_pkg::ST_SETTLE && tick && q.settle_cnt == SETTLE_LAST
			&& !cs_n_s && supply_ok_s;
	endsequence

	sequence s_conv_started;
		q.st == adc_seq_pkg::ST_CONVERT && q.conv_cnt == '0;
	endsequence

	property p_settle_to_convert;
		s_settle_done |=> s_conv_started;
	endproperty
	a_settle_to_convert: assert property (p_settle_to_convert)
		else $error("settling end did not start a conversion");

	property p_convert_after_settle;
		(q.st == adc_seq_pkg::ST_CONVERT && $past(q.st) != adc_seq_pkg::ST_CONVERT)
			|-> $past(q.settle_cnt) == SETTLE_LAST && $past(tick) && !$past(cs_n_s);
	endproperty
	a_convert_after_settle: assert property (p_convert_after_settle)
		else $error("conversion began without full settling");

	property p_first_extra_end;
		(q.st == adc_seq_pkg::ST_CONVERT && q.first && tick && q.conv_cnt == FIRST_LAST
			&& !cs_n_s && supply_ok_s)
			|=> q.st == adc_seq_pkg::ST_SLEEP && o_conv_done && !o_data_out_ready_pin;
	endproperty
	a_first_extra_end: assert property (p_first_extra_end)
		else $error("first conversion did not end after extra periods");

	property p_first_not_early;
		(q.st == adc_seq_pkg::ST_CONVERT && q.first && tick && q.conv_cnt == CONV_LAST
			&& !cs_n_s && supply_ok_s) |=> q.st == adc_seq_pkg::ST_CONVERT;
	endproperty
	a_first_not_early: assert property (p_first_not_early)
		else $error("first conversion ended without extra periods");

	property p_shutdown_quiet;
		q.st == adc_seq_pkg::ST_SHUTDOWN |-> !o_osc_run && !o_analog_en && !tick;
	endproperty
	a_shutdown_quiet: assert property (p_shutdown_quiet)
		else $error("oscillator or analog active in shutdown");

	property p_supply_low_reset;
		(!supply_ok_s && q.st != adc_seq_pkg::ST_SHUTDOWN)
			|=> q.st == adc_seq_pkg::ST_RESET && !o_conv_active;
	endproperty
	a_supply_low_reset: assert property (p_supply_low_reset)
		else $error("low supply did not force reset");

	property p_shutdown_clear;
		q.st == adc_seq_pkg::ST_SHUTDOWN |-> q.settle_cnt == '0 && q.conv_cnt == '0;
	endproperty
	a_shutdown_clear: assert property (p_shutdown_clear)
		else $error("counters not cleared in shutdown");

	property p_busy_pin;
		(q.st == adc_seq_pkg::ST_CONVERT && $past(q.st) == adc_seq_pkg::ST_CONVERT)
			|-> o_data_out_ready_oe && o_data_out_ready_pin;
	endproperty
	a_busy_pin: assert property (p_busy_pin)
		else $error("pin not driven high during conversion");

	property p_idle_state;
		!o_conv_active |-> q.st != adc_seq_pkg::ST_CONVERT;
	endproperty
	a_idle_state: assert property (p_idle_state)
		else $error("converting while reported idle");

	property p_done_to_sleep;
		o_conv_done |-> q.st == adc_seq_pkg::ST_SLEEP && !o_conv_active
			&& o_data_out_ready_oe && !o_data_out_ready_pin;
	endproperty
	a_done_to_sleep: assert property (p_done_to_sleep)
		else $error("conversion end did not enter sleep with ready shown");

	property p_sleep_hold;
		(q.st == adc_seq_pkg::ST_SLEEP && !cs_n_s && supply_ok_s)
			|=> q.st == adc_seq_pkg::ST_SLEEP && $stable(q.word);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold)
		else $error("sleep left or result lost while selected");

	property p_settle_fresh;
		(q.st == adc_seq_pkg::ST_SETTLE && $past(q.st) != adc_seq_pkg::ST_SETTLE)
			|-> q.settle_cnt == '0 && q.conv_cnt == '0 && o_osc_run && o_analog_en;
	endproperty
	a_settle_fresh: assert property (p_settle_fresh)
		else $error("settling did not start from a cleared count");

endmodule
`default_nettype wire

// *** host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input  wire logic i_clk,
	input  wire logic i_pin,
	input  wire logic i_oe,
	output logic      o_cs_n,
	output logic      o_sck
);
	logic last_q = 1'b0;
	logic line;
	// Released line shows a changing pattern, never a stale bit
	assign line = i_oe ? i_pin : ~last_q;
	always @(posedge i_clk) last_q <= line;
	initial
	begin
		o_cs_n = 1'b0;
		o_sck  = 1'b1;
	end
	task automatic select();
		@(negedge i_clk) o_cs_n = 1'b0;
	endtask
	task automatic release_cs();
		@(negedge i_clk) o_cs_n = 1'b1;
	endtask
	// Clock idles high and stands still between frames
	task automatic read_word(output logic [23:0] w);
		w = 24'h0;
		repeat (24)
		begin
			@(negedge i_clk) o_sck = 1'b0;
			repeat (4) @(negedge i_clk);
			o_sck = 1'b1;
			repeat (4) @(negedge i_clk);
			w = {w[22:0], line};
		end
	endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int unsigned P = 5;
	localparam int unsigned N = 16;
	logic        clk;
	logic        rst_n;
	logic        cs_n;
	logic        sck;
	logic        sup;
	logic [21:0] code;
	logic        overflow_high_flag;
	logic        overflow_low_flag;
	logic        pin;
	logic        oe;
	logic        osc;
	logic        ana;
	logic        act;
	logic        done;
	logic [23:0] w;
	int          err_count;
	int          check_count;
	int          done_cnt;

	host_model host (.i_clk(clk), .i_pin(pin), .i_oe(oe), .o_cs_n(cs_n), .o_sck(sck));
	// Fast oscillator keeps the run short: one period is P clocks
	adc_power_state_sequencer #(.OSC_HZ(5_000_000), .CONV_PERIODS(N)) uut (
		.i_clk(clk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_sck(sck),
		.i_supply_ok(sup), .i_code(code), .i_over_high(overflow_high_flag), .i_over_low(overflow_low_flag),
		.o_data_out_ready_pin(pin), .o_data_out_ready_oe(oe), .o_osc_run(osc),
		.o_analog_en(ana), .o_conv_active(act), .o_conv_done(done)
	);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (done === 1'b1) done_cnt++;

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Clocks until done, busy flag drops if pin not high while converting
	task automatic time_conv(output int n, output logic busy);
		n = 0;
		busy = 1'b1;
		while (done !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			#1;
			n++;
			if (act === 1'b1 && pin !== 1'b1) busy = 1'b0;
		end
		@(negedge clk);
	endtask
	task automatic in_range(input int n, input int lo, input int hi);
		check({23'h0, n >= lo && n <= hi}, 24'h1);
	endtask

	task automatic t_powerup();
		int   n;
		logic b;
		wait_clk(4);
		rst_n = 1'b1;
		time_conv(n, b);
		in_range(n, 3 + 48 * P - 2, 3 + 48 * P + 5);
		check(b, 1'b1);
		check({pin, oe, act}, 3'b010);
		host.read_word(w);
		check(w, {overflow_low_flag, overflow_high_flag, code});
		$display("test powerup done");
	endtask
	task automatic t_restart(input logic [23:0] word, input logic tap);
		int   n;
		logic b;
		logic [23:0] junk;
		{overflow_low_flag, overflow_high_flag, code} = word;
		host.release_cs();
		wait_clk(10);
		check({osc, ana, oe}, 3'b000);
		wait_clk(100);
		check({osc, act}, 2'b00);
		host.select();
		fork
			time_conv(n, b);
			if (tap)
			begin
				wait_clk(300);
				host.read_word(junk);
			end
		join
		// Extra periods apply only to the first conversion after shutdown
		in_range(n, 3 + 192 * P - 2, 3 + 192 * P + 5);
		check(b, 1'b1);
		host.read_word(w);
		check(w, word);
		wait_clk(400);
		check({act, osc, pin}, {2'b01, word[0]});
		$display("test restart done");
	endtask
	// Abort mid-conversion, then a restart must run the full count again
	task automatic t_abort();
		int   n;
		logic b;
		host.release_cs();
		wait_clk(10);
		host.select();
		wait_clk(400);
		check(act, 1'b1);
		host.release_cs();
		wait_clk(10);
		check({act, osc, ana, oe}, 4'b0000);
		sup = 1'b0;
		wait_clk(10);
		check({ana, osc}, 2'b00);
		sup = 1'b1;
		wait_clk(10);
		host.select();
		time_conv(n, b);
		in_range(n, 3 + 192 * P - 2, 3 + 192 * P + 5);
		check(b, 1'b1);
		$display("test abort done");
	endtask
	task automatic t_supply();
		int   n;
		int   d;
		logic b;
		host.release_cs();
		wait_clk(10);
		host.select();
		wait_clk(400);
		check(act, 1'b1);
		d = done_cnt;
		sup = 1'b0;
		wait_clk(10);
		check({act, osc}, 2'b00);
		wait_clk(1200);
		check(24'(done_cnt - d), 24'h0);
		sup = 1'b1;
		time_conv(n, b);
		in_range(n, 3 + 48 * P - 2, 3 + 48 * P + 6);
		$display("test supply done");
	endtask

	initial
	begin
		rst_n = 1'b0;
		sup = 1'b1;
		{overflow_low_flag, overflow_high_flag, code} = 24'h2aaaa5;
		err_count = 0;
		check_count = 0;
		done_cnt = 0;
		t_powerup();
		t_restart(24'h600001, 1'b0);
		t_restart(24'h9ffffe, 1'b1);
		t_abort();
		t_supply();
		print_verdict();
	end
	initial
	begin
		#500000;
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
